//--- hw/ctlio_ports.sv
module ctlio_ports (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_alt_base,
  input  wire logic        i_bus_valid,
  input  wire logic        i_bus_rw,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_wdata,
  output logic      [7:0]  o_bus_rdata,
  output logic             o_bus_rdata_oe,
  input  wire logic [63:0] i_field_in_n,
  output logic      [55:0] o_field_out,
  output logic             o_phase_char_sel,
  output logic             o_interval_char_sel,
  output logic             o_least_significant_digit,
  output logic             o_second_lowest_digit,
  output logic             o_second_highest_digit,
  output logic             o_most_significant_digit,
  output logic      [3:0]  o_char_code,
  output logic             o_decimal_point,
  output logic             o_blank_phase_interval,
  output logic             o_blank_timing,
  output logic      [9:0]  o_call_light
);
  import ctlio_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // The strap and field inputs are asynchronous, so each passes two flops.
  logic        alt_meta_reg;
  logic        alt_sync_reg;
  logic [63:0] in_meta_reg;
  logic [63:0] in_sync_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_meta_reg <= 1'b0;
      alt_sync_reg <= 1'b0;
      in_meta_reg  <= '1;
      in_sync_reg  <= '1;
    end else begin
      alt_meta_reg <= i_alt_base;
      alt_sync_reg <= alt_meta_reg;
      in_meta_reg  <= i_field_in_n;
      in_sync_reg  <= in_meta_reg;
    end
  end

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic in_range(input logic [3:0] ofs, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (ofs >= lo) && (ofs <= hi);
  endfunction

  wire logic [15:0] base_addr = alt_sync_reg ? CTLIO_BASE_ALT : CTLIO_BASE_STD;
  wire logic        page_hit  = (i_bus_addr[15:4] == base_addr[15:4]);
  wire logic [3:0]  ofs       = i_bus_addr[3:0];
  wire logic        out_hit   = page_hit && in_range(ofs, CTLIO_OFS_OUT_FIRST, CTLIO_OFS_CALL);
  wire logic        in_hit    = page_hit && in_range(ofs, CTLIO_OFS_IN_FIRST, CTLIO_OFS_IN_LAST);
  wire logic        wr_hit    = i_bus_valid && !i_bus_rw && out_hit;
  wire logic        rd_hit    = i_bus_valid && i_bus_rw && in_hit;
  wire logic [3:0]  out_idx   = ofs - CTLIO_OFS_OUT_FIRST;
  wire logic [2:0]  in_idx    = 3'(ofs - CTLIO_OFS_IN_FIRST);

  // ==========================================================================
  // Output latches
  // ==========================================================================
  // Reset stands for the power-fail condition, so all latches go inactive.
  logic [7:0] out_reg [CTLIO_N_OUT_PORTS];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CTLIO_N_OUT_PORTS; i++) begin
        out_reg[i] <= CTLIO_OUT_RESET;
      end
    end else if (wr_hit) begin
      out_reg[out_idx] <= i_bus_wdata;
    end
  end

  for (genvar g = 0; g < CTLIO_N_FIELD_PORTS; g++) begin : g_field
    assign o_field_out[g*8 +: 8] = out_reg[g];
  end

  wire logic [7:0] pos_byte  = out_reg[CTLIO_OFS_POS_SEL - CTLIO_OFS_OUT_FIRST];
  wire logic [7:0] char_byte = out_reg[CTLIO_OFS_CHAR - CTLIO_OFS_OUT_FIRST];
  wire logic [7:0] call_byte = out_reg[CTLIO_OFS_CALL - CTLIO_OFS_OUT_FIRST];

  assign o_phase_char_sel          = pos_byte[POS_PHASE_BIT];
  assign o_interval_char_sel       = pos_byte[POS_INTERVAL_BIT];
  assign o_least_significant_digit = pos_byte[POS_DIGIT_LSB];
  assign o_second_lowest_digit     = pos_byte[POS_DIGIT_LSB + 1];
  assign o_second_highest_digit    = pos_byte[POS_DIGIT_LSB + 2];
  assign o_most_significant_digit  = pos_byte[POS_DIGIT_LSB + 3];
  assign o_char_code               = char_byte[CHR_CODE_LSB +: 4];
  assign o_decimal_point           = char_byte[CHR_DP_BIT];
  assign o_blank_phase_interval    = char_byte[CHR_BLANK_PI_BIT];
  assign o_blank_timing            = char_byte[CHR_BLANK_TIM_BIT];
  assign o_call_light = {pos_byte[POS_CALL9_BIT], pos_byte[POS_CALL8_BIT], call_byte};

  // ==========================================================================
  // Input read path
  // ==========================================================================
  // Pins are ground true: a low pin reads as one, an open (pulled high) pin
  // as zero. The answer is registered, one cycle after the request.
  wire logic [63:0] in_true = ~in_sync_reg;
  wire logic [7:0]  rd_byte = in_true[in_idx*8 +: 8];
  logic [7:0] rdata_reg;
  logic       rdata_oe_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg    <= 8'h00;
      rdata_oe_reg <= 1'b0;
    end else begin
      rdata_reg    <= rd_hit ? rd_byte : 8'h00;
      rdata_oe_reg <= rd_hit;
    end
  end

  assign o_bus_rdata    = rdata_reg;
  assign o_bus_rdata_oe = rdata_oe_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Display pins gathered so that a stray change on any one of them is caught.
  wire logic [12:0] disp_view = {o_blank_timing, o_blank_phase_interval, o_decimal_point,
                                 o_char_code, o_most_significant_digit,
                                 o_second_highest_digit, o_second_lowest_digit,
                                 o_least_significant_digit, o_interval_char_sel,
                                 o_phase_char_sel};

  write_latch_a: assert property (
      wr_hit |=> out_reg[$past(out_idx)] == $past(i_bus_wdata))
    else $error("Written byte not latched.");

  field_write_a: assert property (
      wr_hit && ofs <= CTLIO_OFS_FIELD_LAST
      |=> o_field_out[$past(out_idx)*8 +: 8] == $past(i_bus_wdata))
    else $error("Field port not driven by its write.");

  hold_value_a: assert property (
      !wr_hit |=> $stable(o_field_out) && $stable(o_call_light))
    else $error("Output changed without a write.");

  display_hold_a: assert property (
      !wr_hit |=> $stable(disp_view))
    else $error("Display pins changed without a write.");

  position_map_a: assert property (
      wr_hit && ofs == CTLIO_OFS_POS_SEL
      |=> disp_view[5:0] == $past(i_bus_wdata[5:0]))
    else $error("Position select mismatch.");

  call_pos_a: assert property (
      wr_hit && ofs == CTLIO_OFS_POS_SEL
      |=> o_call_light[9:8] == $past(i_bus_wdata[7:6]) && $stable(o_call_light[7:0]))
    else $error("Position byte call lights wrong.");

  call_map_a: assert property (
      wr_hit && ofs == CTLIO_OFS_CALL
      |=> o_call_light[7:0] == $past(i_bus_wdata) && $stable(o_call_light[9:8]))
    else $error("Call lights wrong.");

  char_map_a: assert property (
      wr_hit && ofs == CTLIO_OFS_CHAR
      |=> disp_view[12:6] == $past(i_bus_wdata[6:0]))
    else $error("Character byte wrong.");

  read_drive_a: assert property (
      rd_hit |=> o_bus_rdata_oe ##1 !o_bus_rdata_oe || $past(rd_hit))
    else $error("Read drive not one cycle.");

  bus_release_a: assert property (
      !rd_hit |=> !o_bus_rdata_oe && o_bus_rdata == 8'h00)
    else $error("Bus not released.");

  ground_true_a: assert property (
      rd_hit |=> o_bus_rdata == ~$past(in_sync_reg[in_idx*8 +: 8]))
    else $error("Input polarity wrong.");

  read_no_write_a: assert property (
      i_bus_valid && i_bus_rw |=> $stable(o_field_out) && $stable(o_call_light)
                                  && $stable(disp_view))
    else $error("Read altered outputs.");

  refused_page_a: assert property (
      i_bus_valid && !page_hit
      |=> $stable(o_field_out) && $stable(o_call_light) && $stable(disp_view)
          && !o_bus_rdata_oe)
    else $error("Access outside the active page took effect.");

  // Reset is the condition under test here, so the default disable is overridden.
  reset_clear_a: assert property (@(posedge i_clk) disable iff (1'b0)
      !i_rst_n |-> o_field_out == '0 && o_call_light == '0 && disp_view == '0
                   && !o_bus_rdata_oe)
    else $error("Outputs active in reset.");

  // ==========================================================================
  // Coverage
  // ==========================================================================
  // Back-to-back reads are legal on the bus even though a slow host never issues them.
  cov_write_call: cover property (wr_hit && ofs == CTLIO_OFS_CALL);
  cov_write_char: cover property (wr_hit && ofs == CTLIO_OFS_CHAR);
  cov_read_last:  cover property (rd_hit && ofs == CTLIO_OFS_IN_LAST);
  cov_alt_write:  cover property (alt_sync_reg && wr_hit && ofs == CTLIO_OFS_CALL);
  cov_back2back:  cover property (rd_hit ##1 rd_hit);

endmodule

//--- hw/ctlio_pkg.sv
package ctlio_pkg;

  // ==========================================================================
  // Port address map
  // ==========================================================================
  localparam logic [15:0] CTLIO_BASE_STD      = 16'h5000;
  localparam logic [15:0] CTLIO_BASE_ALT      = 16'h7400;
  localparam logic [3:0]  CTLIO_OFS_IN_FIRST  = 4'h1;
  localparam logic [3:0]  CTLIO_OFS_IN_LAST   = 4'h8;
  localparam logic [3:0]  CTLIO_OFS_OUT_FIRST = 4'h1;
  localparam logic [3:0]  CTLIO_OFS_FIELD_LAST = 4'h7;

  // Display and call-light byte addresses at each base, and their offsets.
  localparam logic [15:0] DISPLAY_POSITION_SELECT     = 16'h5008;
  localparam logic [15:0] DISPLAY_CHARACTER_DATA      = 16'h5009;
  localparam logic [15:0] CALL_LIGHT_OUTPUTS          = 16'h500A;
  localparam logic [15:0] DISPLAY_POSITION_SELECT_ALT = 16'h7408;
  localparam logic [15:0] DISPLAY_CHARACTER_DATA_ALT  = 16'h7409;
  localparam logic [15:0] CALL_LIGHT_OUTPUTS_ALT      = 16'h740A;
  localparam logic [3:0]  CTLIO_OFS_POS_SEL  = 4'h8;
  localparam logic [3:0]  CTLIO_OFS_CHAR     = 4'h9;
  localparam logic [3:0]  CTLIO_OFS_CALL     = 4'hA;

  // ==========================================================================
  // Sizes, field positions and reset values
  // ==========================================================================
  localparam int          CTLIO_N_IN_PORTS    = 8;
  localparam int          CTLIO_N_OUT_PORTS   = 10;
  localparam int          CTLIO_N_FIELD_PORTS = 7;
  localparam logic [7:0]  CTLIO_OUT_RESET     = 8'h00;
  localparam int          POS_PHASE_BIT       = 0;
  localparam int          POS_INTERVAL_BIT    = 1;
  localparam int          POS_DIGIT_LSB       = 2;
  localparam int          POS_CALL8_BIT       = 6;
  localparam int          POS_CALL9_BIT       = 7;
  localparam int          CHR_CODE_LSB        = 0;
  localparam int          CHR_DP_BIT          = 4;
  localparam int          CHR_BLANK_PI_BIT    = 5;
  localparam int          CHR_BLANK_TIM_BIT   = 6;

endpackage

//--- tb/ctlio_host.sv
// ============================================================
// Host processor model driving the parallel I/O bus
// ============================================================
module ctlio_host (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_rdata,
  input  wire logic        i_oe,
  output logic             o_valid,
  output logic             o_rw,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_valid = 1'b0;
    o_rw    = 1'b1;
    o_addr  = 16'h0000;
    o_wdata = 8'h00;
  end

  // One byte access; the answer is taken one cycle after the taking edge.
  task automatic access(input logic rw, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic oe);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_rw    <= rw;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    // Released lines flip so that a stale address or byte can never be mistaken for a new one.
    o_addr  <= ~a;
    o_wdata <= ~d;
    @(posedge i_clk);
    q  = i_rdata;
    oe = i_oe;
    #1;
  endtask
endmodule

//--- tb/tb_controller_io_ports.sv
module tb_controller_io_ports;
  timeunit 1ns;
  timeprecision 1ps;
  import ctlio_pkg::*;
  logic        clk, rst_n, alt_base, valid, rw, oe, qoe;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, q;
  logic [63:0] fin_n;
  logic [55:0] fout;
  logic        ph, iv, d0, d1, d2, d3, dp, bpi, btim;
  logic [3:0]  code;
  logic [9:0]  call;
  int          mismatches, check_count, cyc, k;
  wire  [7:0]  pos_v   = {call[9:8], d3, d2, d1, d0, iv, ph};
  wire  [6:0]  chr_v   = {btim, bpi, dp, code};
  wire  [95:0] all_out = {8'h00, fout, call, pos_v[5:0], chr_v, rdata, oe};
  localparam logic [63:0] PAT = 64'h0123456789ABCDEF;

  ctlio_ports dut (.i_clk(clk), .i_rst_n(rst_n), .i_alt_base(alt_base), .i_bus_valid(valid),
    .i_bus_rw(rw), .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
    .o_bus_rdata_oe(oe), .i_field_in_n(fin_n), .o_field_out(fout), .o_phase_char_sel(ph),
    .o_interval_char_sel(iv), .o_least_significant_digit(d0), .o_second_lowest_digit(d1),
    .o_second_highest_digit(d2), .o_most_significant_digit(d3), .o_char_code(code),
    .o_decimal_point(dp), .o_blank_phase_interval(bpi), .o_blank_timing(btim),
    .o_call_light(call));
  ctlio_host host (.i_clk(clk), .i_rdata(rdata), .i_oe(oe), .o_valid(valid), .o_rw(rw),
    .o_addr(addr), .o_wdata(wdata));

  // ============================================================
  // Clock, timeout and checking
  // ============================================================
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.access(1'b0, a, d, q, qoe);
  endtask
  task automatic rd(input logic [15:0] a);
    host.access(1'b1, a, 8'h00, q, qoe);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ============================================================
  // Test sequence
  // ============================================================
  initial begin
    clk = 1'b0;
    rst_n <= 1'b0;
    alt_base = 1'b0;
    fin_n = {64{1'b1}};
    repeat (3) @(posedge clk);
    chk(all_out, 96'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 8; k++) begin
      wr(DISPLAY_POSITION_SELECT, 8'h01 << k);
      chk(96'(pos_v), 96'(8'h01 << k));
      wr(DISPLAY_CHARACTER_DATA, 8'h01 << k);
      chk(96'(chr_v), 96'(7'(8'h01 << k)));
    end
    wr(CALL_LIGHT_OUTPUTS, 8'hA5);
    chk(96'(call[7:0]), 96'(8'hA5));
    for (k = 1; k < 8; k++) wr(CTLIO_BASE_STD + 16'(k), 8'(k * 17));
    // Refused addresses and a read of an output address must leave the field latches alone.
    wr(16'h500B, 8'hFF);
    wr(16'h5000, 8'hFF);
    wr(16'h7001, 8'hFF);
    rd(16'h5001);
    chk(96'({qoe, q}), 96'(9'h100));
    chk(96'(fout), 96'(56'h77665544332211));
    @(posedge clk);
    fin_n <= PAT;
    repeat (3) @(posedge clk);
    for (k = 1; k < 9; k++) begin
      rd(CTLIO_BASE_STD + 16'(k));
      chk(96'({qoe, q}), 96'({1'b1, ~PAT[8*(k-1) +: 8]}));
    end
    rd(16'h5009);
    chk(96'({qoe, q}), 96'(9'h000));
    @(posedge clk);
    alt_base <= 1'b1;
    repeat (3) @(posedge clk);
    wr(CALL_LIGHT_OUTPUTS_ALT, 8'h3C);
    wr(CALL_LIGHT_OUTPUTS, 8'hFF);
    // The last position byte written had its top bit set, so call light 9 stays lit.
    chk(96'(call), 96'(10'h23C));
    rd(16'h7402);
    chk(96'({qoe, q}), 96'({1'b1, ~PAT[15:8]}));
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(all_out, 96'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(16'h7403);
    chk(96'({qoe, q}), 96'({1'b1, ~PAT[23:16]}));
    chk(all_out, 96'h0);
    summarize();
  end
endmodule
